/* hdl/scgf_pin_sync.sv */
// Two-stage synchroniser for all pin inputs of the control block
`default_nettype none

module scgf_pin_sync
  import scgf_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   srst_i,
  scgf_pin_if.sync_mp pins
);

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
  } scgf_sync_t;

  scgf_sync_t st_r;
  scgf_sync_t st_nxt;

  // Only the second stage is read, the first may be metastable
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pins.raw;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins.synced = st_r.s2;

endmodule // scgf_pin_sync

`default_nettype wire

/* hdl/scgf_top.sv */
// Strap capture, fundamental reset and general-purpose pin function control
//
// Added by the designer: the register addresses and the APB interface to the registers.
`default_nettype none

module scgf_top
  import scgf_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [DATA_W-1:0] pwdata_i,
  output logic      [DATA_W-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // System pins
  input  wire logic              fundamental_reset_n_i,
  input  wire logic [2:0]        switch_mode_strap_i,
  input  wire logic              common_clock_downstream_strap_i,
  input  wire logic              common_clock_upstream_strap_i,
  // General-purpose pins
  input  wire logic [GPIO_W-1:0] gpio_i,
  output logic      [GPIO_W-1:0] gpio_o,
  output logic      [GPIO_W-1:0] gpio_oe_o,
  // Alternate-function load from SMBus slave or EEPROM loader
  input  wire logic              alt_load_i,
  input  wire logic [GPIO_W-1:0] alt_load_value_i,
  // Status towards the rest of the switch
  output logic                   pcie_fund_reset_o,
  output logic      [2:0]        switch_mode_o,
  output logic                   eeprom_init_o,
  output logic                   mode_reserved_o,
  output logic      [PORT_N-1:0] slot_clock_cfg_o,
  output logic                   expander_int_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [GPIO_W-1:0] gpio_out;
    logic [GPIO_W-1:0] gpio_dir;
    logic [GPIO_W-1:0] gpio_alt;
    logic [PORT_N-1:0] sclk;
    logic [3:1]        ds_rst;
    logic              gpe;
    logic [2:0]        mode;
    logic              cclk_ds;
    logic              cclk_us;
    logic              captured;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
    logic [GPIO_W-1:0] pin_out;
    logic [GPIO_W-1:0] pin_oe;
    logic              fund_rst;
    logic              exp_int;
    logic              eeprom;
    logic              rsvd;
  } scgf_state_t;

  localparam scgf_state_t ST_RESET = '{
    gpio_out: RST_GPIO_OUT,
    gpio_dir: RST_GPIO_DIR,
    gpio_alt: RST_GPIO_ALT,
    sclk:     RST_SCLK,
    ds_rst:   RST_DS_RST,
    fund_rst: 1'b1,
    default:  '0
  };

  scgf_state_t st_r;
  scgf_state_t st_nxt;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  scgf_pin_if pin_if ();

  assign pin_if.raw = {fundamental_reset_n_i, common_clock_upstream_strap_i,
                       common_clock_downstream_strap_i, switch_mode_strap_i, gpio_i};

  scgf_pin_sync u_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .pins   (pin_if.sync_mp)
  );

  logic [GPIO_W-1:0] gpio_s;
  logic [2:0]        mode_s;
  logic              cclk_ds_s;
  logic              cclk_us_s;
  logic              fund_n_s;

  assign {fund_n_s, cclk_us_s, cclk_ds_s, mode_s, gpio_s} = pin_if.synced;

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= OFS_GPE);
  endfunction

  function automatic logic mode_is_eeprom(input logic [2:0] m);
    mode_is_eeprom = (m == MODE_EEPROM); // R1
  endfunction

  function automatic logic mode_is_rsvd(input logic [2:0] m);
    mode_is_rsvd = (m != MODE_NORMAL) && (m != MODE_EEPROM); // R1
  endfunction

  // Downstream port whose reset a pin carries, zero for none
  function automatic logic [1:0] rst_port(input int pin);
    case (pin)
      PIN_P1_RST: rst_port = 2'h1;
      PIN_P2_RST: rst_port = 2'h2;
      PIN_P3_RST: rst_port = 2'h3;
      default:    rst_port = 2'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic              wr;
    logic [DATA_W-1:0] rd;
    logic [1:0]        port;
    wr     = 1'b0;
    rd     = '0;
    port   = 2'h0;
    st_nxt = st_r;

    // Read mux, unmapped offsets read zero
    case (paddr_i)
      OFS_GPIO_OUT: rd[GPIO_W-1:0] = st_r.gpio_out;
      OFS_GPIO_DIR: rd[GPIO_W-1:0] = st_r.gpio_dir;
      OFS_GPIO_ALT: rd[GPIO_W-1:0] = st_r.gpio_alt;
      OFS_GPIO_IN:  rd[GPIO_W-1:0] = gpio_s & GPIO_IMPL;
      OFS_STRAP: begin
        rd[STS_MODE_LSB +: 3] = st_r.mode;
        rd[STS_EEPROM]        = mode_is_eeprom(st_r.mode); // R1
        rd[STS_RSVD]          = mode_is_rsvd(st_r.mode); // R1
        rd[STS_CCLK_DS]       = st_r.cclk_ds;
        rd[STS_CCLK_US]       = st_r.cclk_us;
        rd[STS_VALID]         = st_r.captured;
      end
      OFS_SCLK:     rd[PORT_N-1:0] = st_r.sclk;
      OFS_DS_RST:   rd[3:1] = st_r.ds_rst;
      OFS_GPE:      rd[0] = st_r.gpe;
      default:      rd = '0;
    endcase

    // One wait state: answer in the cycle after the access phase opens
    st_nxt.pready = 1'b0;
    if (psel_i && penable_i && !st_r.pready) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = !addr_ok(paddr_i);
      st_nxt.prdata  = pwrite_i ? '0 : rd;
    end
    wr = psel_i && penable_i && pwrite_i && st_r.pready && addr_ok(paddr_i);

    if (wr) begin
      case (paddr_i)
        OFS_GPIO_OUT: st_nxt.gpio_out = pwdata_i[GPIO_W-1:0] & GPIO_IMPL;
        OFS_GPIO_DIR: st_nxt.gpio_dir = pwdata_i[GPIO_W-1:0] & GPIO_IMPL;
        OFS_GPIO_ALT: st_nxt.gpio_alt = pwdata_i[GPIO_W-1:0] & GPIO_IMPL; // R12
        OFS_SCLK:     st_nxt.sclk = pwdata_i[PORT_N-1:0]; // R6
        OFS_DS_RST:   st_nxt.ds_rst = pwdata_i[3:1];
        OFS_GPE:      st_nxt.gpe = pwdata_i[0];
        default:      st_nxt.gpe = st_r.gpe;
      endcase
    end

    // Loader wins over a software write in the same cycle
    if (alt_load_i) begin
      st_nxt.gpio_alt = alt_load_value_i & GPIO_IMPL; // R12
    end

    // Fundamental reset clears every register but leaves the bus answering
    if (!fund_n_s) begin
      st_nxt.gpio_out = RST_GPIO_OUT; // R3
      st_nxt.gpio_dir = RST_GPIO_DIR; // R3
      st_nxt.gpio_alt = RST_GPIO_ALT; // R3
      st_nxt.sclk     = RST_SCLK; // R3
      st_nxt.ds_rst   = RST_DS_RST; // R3
      st_nxt.gpe      = 1'b0;
      st_nxt.mode     = MODE_NORMAL;
      st_nxt.cclk_ds  = 1'b0;
      st_nxt.cclk_us  = 1'b0;
      st_nxt.captured = 1'b0;
    end else if (!st_r.captured) begin
      // Sampled once per release; later strap motion is ignored
      st_nxt.mode     = mode_s; // R13
      st_nxt.cclk_ds  = cclk_ds_s;
      st_nxt.cclk_us  = cclk_us_s;
      st_nxt.sclk     = {{(PORT_N-1){cclk_ds_s}}, cclk_us_s}; // R4 R5
      st_nxt.captured = 1'b1; // R13
    end
    st_nxt.fund_rst = !fund_n_s; // R3 R11
    st_nxt.eeprom   = mode_is_eeprom(st_nxt.mode); // R1
    st_nxt.rsvd     = mode_is_rsvd(st_nxt.mode); // R1

    // Pins follow the next register values so they move with the write
    for (int i = 0; i < GPIO_W; i++) begin
      port = rst_port(i);
      if (st_nxt.gpio_alt[i] && (port != 2'h0)) begin
        st_nxt.pin_oe[i]  = 1'b1; // R8
        st_nxt.pin_out[i] = !st_nxt.ds_rst[port]; // R8 R11
      end else if (st_nxt.gpio_alt[i] && (i == PIN_GPE)) begin
        st_nxt.pin_oe[i]  = 1'b1; // R10
        st_nxt.pin_out[i] = !st_nxt.gpe; // R10 R11
      end else if (st_nxt.gpio_alt[i] && (i == PIN_EXP_INT)) begin
        st_nxt.pin_oe[i]  = 1'b0; // R9
        st_nxt.pin_out[i] = 1'b0;
      end else begin
        st_nxt.pin_oe[i]  = st_nxt.gpio_dir[i]; // R7
        st_nxt.pin_out[i] = st_nxt.gpio_out[i]; // R7
      end
    end
    st_nxt.exp_int = st_nxt.gpio_alt[PIN_EXP_INT] && !gpio_s[PIN_EXP_INT]; // R9 R11
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o          = st_r.prdata;
  assign pready_o          = st_r.pready;
  assign pslverr_o         = st_r.pslverr;
  assign gpio_o            = st_r.pin_out;
  assign gpio_oe_o         = st_r.pin_oe;
  assign pcie_fund_reset_o = st_r.fund_rst;
  assign switch_mode_o     = st_r.mode;
  assign eeprom_init_o     = st_r.eeprom;
  assign mode_reserved_o   = st_r.rsvd;
  assign slot_clock_cfg_o  = st_r.sclk;
  assign expander_int_o    = st_r.exp_int;

endmodule // scgf_top

`default_nettype wire

/* include/scgf_pin_if.sv */
// Carrier between the pin synchroniser and the control core
`default_nettype none

interface scgf_pin_if;
  import scgf_pkg::*;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] synced;

  modport sync_mp (input raw, output synced);
  modport core_mp (input synced);
endinterface : scgf_pin_if

`default_nettype wire

/* include/scgf_pkg.sv */
// Constants, register map and field layout for the strap and pin function control block
//
// Function
// R1: The three-bit switch mode strap decodes 0x0 as normal mode, 0x1 as normal mode with EEPROM initialization, and 0x2 to 0x7 as reserved.
// R2: The board keeps the switch mode strap pins steady after fundamental reset is released.
// R3: While fundamental reset is low, all internal logic is held in reset and a fundamental reset is signalled onward; the APB bus keeps answering.
// R4: The downstream common-clock strap seeds the slot clock configuration bit of every downstream port.
// R5: The upstream common-clock strap seeds the slot clock configuration bit of the upstream port.
// R6: A software write to a port's slot clock configuration bit replaces the strap-derived value.
// R7: A pin whose alternate function is off works as a plain general-purpose input or output.
// R8: With the alternate function on, pins 0, 8 and 9 drive active-low resets for downstream ports 2, 1 and 3.
// R9: With the alternate function on, pin 2 takes the active-low expander interrupt input.
// R10: With the alternate function on, pin 7 drives the active-low general purpose event output.
// R11: Pin signals named with an n suffix are asserted low, all others asserted high.
// R12: Alternate-function selection can be set by software or by the SMBus slave or EEPROM loader.
// R13: The straps are sampled once when fundamental reset is released and held until the next one.
`default_nettype none

package scgf_pkg;

  // ----------------------------------------------------------------
  // Bus and pin geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 8;
  localparam int          DATA_W    = 32;
  localparam int          GPIO_W    = 11;
  localparam int          PORT_N    = 4;
  localparam int          SYNC_W    = GPIO_W + 6;
  localparam logic [10:0] GPIO_IMPL = 11'h787;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_GPIO_OUT = 8'h00;
  localparam logic [7:0] OFS_GPIO_DIR = 8'h04;
  localparam logic [7:0] OFS_GPIO_ALT = 8'h08;
  localparam logic [7:0] OFS_GPIO_IN  = 8'h0C;
  localparam logic [7:0] OFS_STRAP    = 8'h10;
  localparam logic [7:0] OFS_SCLK     = 8'h14;
  localparam logic [7:0] OFS_DS_RST   = 8'h18;
  localparam logic [7:0] OFS_GPE      = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions of the strap status register
  // ----------------------------------------------------------------
  localparam int STS_MODE_LSB = 0;
  localparam int STS_EEPROM   = 3;
  localparam int STS_RSVD     = 4;
  localparam int STS_CCLK_DS  = 5;
  localparam int STS_CCLK_US  = 6;
  localparam int STS_VALID    = 7;

  // ----------------------------------------------------------------
  // Pin assignment of alternate functions
  // ----------------------------------------------------------------
  localparam int PIN_P2_RST  = 0;
  localparam int PIN_EXP_INT = 2;
  localparam int PIN_GPE     = 7;
  localparam int PIN_P1_RST  = 8;
  localparam int PIN_P3_RST  = 9;

  // ----------------------------------------------------------------
  // Switch mode codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  MODE_NORMAL  = 3'h0;
  localparam logic [2:0]  MODE_EEPROM  = 3'h1;
  localparam logic [10:0] RST_GPIO_OUT = 11'h000;
  localparam logic [10:0] RST_GPIO_DIR = 11'h000;
  localparam logic [10:0] RST_GPIO_ALT = 11'h000;
  localparam logic [3:0]  RST_SCLK     = 4'h0;
  localparam logic [3:1]  RST_DS_RST   = 3'h0;

endpackage : scgf_pkg

`default_nettype wire

/* testbench/scgf_board.sv */
// Board model: pin pull-ups, external drivers and expander interrupt
`default_nettype none
module scgf_board
  import scgf_pkg::*;
(
  input  wire logic [10:0] gpio_o_i,
  input  wire logic [10:0] gpio_oe_i,
  input  wire logic [10:0] ext_en_i,
  input  wire logic [10:0] ext_val_i,
  input  wire logic        exp_irq_i,
  output logic      [10:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] ext;
  // Released pins float up to the pull-up level, never to a stale value
  assign ext = (ext_en_i & ext_val_i) | ~ext_en_i;
  // The expander pulls its open-drain line low while it reports
  assign pin_o = ((gpio_oe_i & gpio_o_i) | (~gpio_oe_i & ext)) & ~{8'h00, exp_irq_i, 2'h0};
endmodule // scgf_board

`default_nettype wire

/* testbench/scgf_props.sv */
// Port properties of scgf_top
`default_nettype none
module scgf_props
  import scgf_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic fundamental_reset_n_i,
  input wire logic alt_load_i,
  input wire logic [10:0] alt_load_value_i,
  input wire logic [10:0] gpio_oe_o,
  input wire logic pcie_fund_reset_o,
  input wire logic [2:0] switch_mode_o,
  input wire logic eeprom_init_o,
  input wire logic mode_reserved_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // Six cycles leave room for the two-stage pin synchroniser
  a_fund_reset_out: assert property (!fundamental_reset_n_i [*6] |-> pcie_fund_reset_o)
    else $error("fundamental reset not passed on");
  a_fund_release: assert property (fundamental_reset_n_i [*6] |-> !pcie_fund_reset_o)
    else $error("fundamental reset stuck");
  a_eeprom_decode: assert property (eeprom_init_o == (switch_mode_o == MODE_EEPROM))
    else $error("eeprom mode decode wrong");
  a_reserved_decode: assert property (mode_reserved_o == (switch_mode_o > MODE_EEPROM))
    else $error("reserved mode decode wrong");
  a_mode_held: assert property (fundamental_reset_n_i [*8] |-> $stable(switch_mode_o))
    else $error("switch mode moved while running");
  a_gpe_drive: assert property (alt_load_i && alt_load_value_i[PIN_GPE] |-> ##[1:3] gpio_oe_o[PIN_GPE])
    else $error("event pin not driven");
  a_exp_input: assert property (alt_load_i && alt_load_value_i[PIN_EXP_INT] |-> ##[1:3] !gpio_oe_o[PIN_EXP_INT])
    else $error("interrupt pin driven");
  a_unimpl_idle: assert property ((gpio_oe_o & ~GPIO_IMPL) == 11'h000)
    else $error("absent pin driven");
endmodule // scgf_props

bind scgf_top scgf_props props_u (.*);

`default_nettype wire

/* testbench/tb_scgf_top.sv */
// Self-checking bench for scgf_top
`default_nettype none
module tb_scgf_top
  import scgf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, alt_load_i, irq;
  logic fundamental_reset_n_i, common_clock_downstream_strap_i, common_clock_upstream_strap_i;
  logic pcie_fund_reset_o, eeprom_init_o, mode_reserved_o, expander_int_o;
  logic [2:0] switch_mode_strap_i, switch_mode_o;
  logic [3:0] slot_clock_cfg_o;
  logic [7:0] paddr_i;
  logic [10:0] gpio_i, gpio_o, gpio_oe_o, alt_load_value_i, ext_en, ext_val;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic err;
  int fails, checks_done;

  scgf_top dut_u (.*);
  scgf_board board_u (.gpio_o_i(gpio_o), .gpio_oe_i(gpio_oe_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .exp_irq_i(irq), .pin_o(gpio_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask

  task automatic t_modes;
    apb(1'b1, OFS_GPIO_DIR, 32'h787);
    apb(1'b0, OFS_GPIO_DIR, 32'h0);
    chk("dir_pre", rd[10:0], 11'h787);
    for (int m = 0; m < 8; m++) begin
      @(posedge clk_i);
      fundamental_reset_n_i <= 1'b0;
      switch_mode_strap_i <= m[2:0];
      {common_clock_downstream_strap_i, common_clock_upstream_strap_i} <= m[1:0];
      repeat (8) @(negedge clk_i);
      chk("fund_rst", pcie_fund_reset_o, 1'b1);
      @(posedge clk_i);
      fundamental_reset_n_i <= 1'b1;
      repeat (10) @(negedge clk_i);
      chk("fund_rst", pcie_fund_reset_o, 1'b0);
      chk("mode", switch_mode_o, m);
      chk("eeprom", eeprom_init_o, m == 1);
      chk("rsvd", mode_reserved_o, m > 1);
      chk("sclk", slot_clock_cfg_o, {{3{m[1]}}, m[0]});
    end
    apb(1'b0, OFS_GPIO_DIR, 32'h0);
    chk("dir", rd[10:0], RST_GPIO_DIR);
  endtask

  task automatic t_sclk;
    apb(1'b1, OFS_SCLK, 32'hA);
    repeat (2) @(negedge clk_i);
    chk("sclk_wr", slot_clock_cfg_o, 4'hA);
    chk("slverr_ok", err, 1'b0);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr_bad", err, 1'b1);
  endtask

  task automatic t_gpio;
    apb(1'b1, OFS_GPIO_DIR, 32'h787);
    apb(1'b1, OFS_GPIO_OUT, 32'h505);
    @(negedge clk_i);
    chk("oe", gpio_oe_o, GPIO_IMPL);
    chk("out", gpio_o & GPIO_IMPL, 11'h505);
    apb(1'b1, OFS_GPIO_DIR, 32'h0);
    ext_en <= GPIO_IMPL;
    ext_val <= 11'h2A3;
    repeat (4) @(posedge clk_i);
    apb(1'b0, OFS_GPIO_IN, 32'h0);
    chk("in", rd[10:0] & GPIO_IMPL, 11'h283);
    ext_en <= 11'h000;
  endtask

  task automatic t_alt;
    @(posedge clk_i);
    {alt_load_i, alt_load_value_i} <= {1'b1, 11'h385};
    @(posedge clk_i);
    alt_load_i <= 1'b0;
    apb(1'b0, OFS_GPIO_ALT, 32'h0);
    chk("alt", rd[10:0], 11'h385);
    apb(1'b1, OFS_DS_RST, 32'h4);
    apb(1'b1, OFS_GPE, 32'h1);
    @(negedge clk_i);
    chk("alt_oe", gpio_oe_o, 11'h381);
    chk("alt_out", gpio_o & 11'h381, 11'h300);
    chk("irq_idle", expander_int_o, 1'b0);
    @(posedge clk_i);
    irq <= 1'b1;
    repeat (5) @(negedge clk_i);
    chk("irq", expander_int_o, 1'b1);
    @(posedge clk_i);
    irq <= 1'b0;
    apb(1'b1, OFS_DS_RST, 32'hA);
    apb(1'b1, OFS_GPE, 32'h0);
    @(negedge clk_i);
    chk("alt_out", gpio_o & 11'h381, 11'h081);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    {fails, checks_done} = 0;
    {srst_i, fundamental_reset_n_i, psel_i, penable_i, pwrite_i, alt_load_i, irq} = 7'h60;
    {paddr_i, pwdata_i, alt_load_value_i, ext_en, ext_val, switch_mode_strap_i} = 0;
    {common_clock_downstream_strap_i, common_clock_upstream_strap_i} = 2'h0;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    t_modes;
    t_sclk;
    t_gpio;
    t_alt;
    results;
  end

  initial begin
    #400000;
    fails++;
    results;
  end
endmodule // tb_scgf_top

`default_nettype wire
